// [include/agc_pkg.sv]
package agc_pkg;

	// Data path widths.
	localparam int IN_W      = 20;
	localparam int OUT_W     = 24;
	localparam int GAIN_W    = 16;
	localparam int EXP_W     = 4;
	localparam int MANT_W    = 12;
	localparam int ACC_W     = 24;
	localparam int FRAC_W    = 8;
	localparam int MAG_IN_W  = 16;
	localparam int MAG_W     = 18;
	localparam int CORD_W    = 20;
	localparam int LG_W      = 8;
	localparam int ERR_W     = MAG_W + 1;
	localparam int SUM_W     = 29;
	localparam int PROD_W    = IN_W + MANT_W + 2;
	localparam int SH_W      = PROD_W + 15;
	localparam int DLY_DEPTH = 16;
	localparam int DLY_AW    = 4;
	localparam int CNT_W     = 16;
	localparam int ADDR_W    = 8;
	localparam int MEAN_SHIFT = 4;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] A_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] A_THRESH  = 8'h04;
	localparam logic [ADDR_W-1:0] A_LGAIN0  = 8'h08;
	localparam logic [ADDR_W-1:0] A_LGAIN1  = 8'h0C;
	localparam logic [ADDR_W-1:0] A_LIMIT   = 8'h10;
	localparam logic [ADDR_W-1:0] A_HOLD    = 8'h14;
	localparam logic [ADDR_W-1:0] A_XFER    = 8'h18;
	localparam logic [ADDR_W-1:0] A_SLOTLEN = 8'h1C;
	localparam logic [ADDR_W-1:0] A_SDELAY  = 8'h20;
	localparam logic [ADDR_W-1:0] A_SINTV   = 8'h24;
	localparam logic [ADDR_W-1:0] A_DLYLEN  = 8'h28;
	localparam logic [ADDR_W-1:0] A_GAIN    = 8'h2C;
	localparam logic [ADDR_W-1:0] A_STATUS  = 8'h30;

	// Control register fields.
	localparam int CB_BYPASS  = 0;
	localparam int CB_DLY     = 1;
	localparam int CB_MODE    = 2;
	localparam int CB_SYNCLD  = 4;
	localparam int CB_SYNCRS  = 5;
	localparam int CB_HGSEL   = 6;
	localparam int CB_HMED    = 7;
	localparam int CB_CNTMODE = 8;
	localparam int CTRL_W     = 9;
	localparam logic [1:0] MODE_CONT    = 2'h0;
	localparam logic [1:0] MODE_TIMED   = 2'h1;
	localparam logic [1:0] MODE_SAMPLED = 2'h2;

	// Loop gain register fields.
	localparam int LG_ATTACK = 0;
	localparam int LG_DECAY  = 8;

	// Sample spacing in clocks; also the number of magnitude passes.
	localparam logic [2:0] SP_BYPASS = 3'h1;
	localparam logic [2:0] SP_NODLY  = 3'h2;
	localparam logic [2:0] SP_DLY    = 3'h4;

	// Reset values and the all-ones fraction fill used by the upper clamp limit.
	localparam logic [CTRL_W-1:0] CTRL_RST   = 9'h000;
	localparam logic [MAG_W-1:0]  THRESH_RST = 18'h0_0000;
	localparam logic [GAIN_W-1:0] LIM_HI_RST = 16'hFFFF;
	localparam logic [GAIN_W-1:0] LIM_LO_RST = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_RST    = 16'h0000;
	localparam logic [FRAC_W-1:0] FRAC_ONES  = 8'hFF;

	localparam logic signed [OUT_W-1:0] SAT_MAX = 24'sh7F_FFFF;
	localparam logic signed [OUT_W-1:0] SAT_MIN = -24'sh80_0000;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b001,
		PH_WAIT = 3'b010,
		PH_INTV = 3'b100
	} agc_phase_e;

endpackage : agc_pkg

// [rtl/agc_mag.sv]
`timescale 1ns/1ps
module agc_mag
	import agc_pkg::*;
(
	// Clock and reset.
	input  wire logic                       clk,
	input  wire logic                       nrst,
	// Request.
	input  wire logic                       start,
	input  wire logic signed [MAG_IN_W-1:0] in_i,
	input  wire logic signed [MAG_IN_W-1:0] in_q,
	input  wire logic [2:0]                 passes,
	// Result.
	output logic                            done,
	output logic [MAG_W-1:0]                mag
);

	logic signed [CORD_W-1:0] x, y, cx, cy, nx, ny;
	logic [2:0]               k, ck, np;
	logic                     busy;

	// One vectoring pass per clock; the first pass runs on the request cycle.
	always_comb begin
		cx = start ? ((in_i < 0) ? -CORD_W'(in_i) : CORD_W'(in_i)) : x;
		cy = start ? CORD_W'(in_q) : y;
		ck = start ? 3'h0 : k;
		if (cy >= 0) begin
			nx = cx + (cy >>> ck);
			ny = cy - (cx >>> ck);
		end else begin
			nx = cx - (cy >>> ck);
			ny = cy + (cx >>> ck);
		end
	end

	// The result keeps the inherent pass-dependent gain; the set point absorbs it.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			x    <= '0;
			y    <= '0;
			k    <= 3'h0;
			np   <= 3'h0;
			busy <= 1'b0;
			done <= 1'b0;
			mag  <= '0;
		end else if (start) begin
			x    <= nx;
			y    <= ny;
			k    <= 3'h1;
			np   <= passes;
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy) begin
			x <= nx;
			y <= ny;
			k <= k + 3'h1;
			if (k == np - 3'h1) begin
				busy <= 1'b0;
				done <= 1'b1;
				mag  <= nx[MAG_W-1:0];
			end
		end else begin
			done <= 1'b0;
		end
	end

	chk_mag_two_pass: assert property (@(posedge clk) disable iff (!nrst)
		start && passes == SP_NODLY |=> !done ##1 done)
		else $error("two-pass magnitude not ready after two clocks");

	chk_mag_four_pass: assert property (@(posedge clk) disable iff (!nrst)
		start && passes == SP_DLY |=> !done[*3] ##1 done)
		else $error("four-pass magnitude not ready after four clocks");

endmodule : agc_mag

// [rtl/agc_loop.sv]
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module agc_loop
	import agc_pkg::*;
(
	// Clock and reset.
	input  wire logic                    CLK_SYS,
	input  wire logic                    NRST,
	// APB slave.
	input  wire logic                    PSEL,
	input  wire logic                    PENABLE,
	input  wire logic                    PWRITE,
	input  wire logic [ADDR_W-1:0]       PADDR,
	input  wire logic [31:0]             PWDATA,
	output logic [31:0]                  PRDATA,
	output logic                         PREADY,
	output logic                         PSLVERR,
	// Slot timing pin.
	input  wire logic                    SLOT_SYNC_INPUT,
	// Sample input from the channel filter.
	input  wire logic                    IN_VALID,
	output logic                         IN_READY,
	input  wire logic signed [IN_W-1:0]  IN_I,
	input  wire logic signed [IN_W-1:0]  IN_Q,
	// Scaled samples and gain toward the rate change section.
	output logic                         OUT_VALID,
	output logic signed [OUT_W-1:0]      OUT_I,
	output logic signed [OUT_W-1:0]      OUT_Q,
	output logic [GAIN_W-1:0]            GAIN_OUT
);

	logic [CTRL_W-1:0]         ctrl;
	logic [MAG_W-1:0]          thresh;
	logic [15:0]               lgain0, lgain1;
	logic [GAIN_W-1:0]         lim_hi, lim_lo, hold;
	logic [CNT_W-1:0]          slot_len, sdelay, sintv, slot_cnt, pcnt;
	logic [DLY_AW-1:0]         dly_len, wp, rd_idx;
	logic [DLY_AW:0]           fill;
	logic signed [IN_W-1:0]    dly_i [DLY_DEPTH];
	logic signed [IN_W-1:0]    dly_q [DLY_DEPTH];
	logic [ACC_W-1:0]          acc, next_acc;
	logic [GAIN_W-1:0]         gain_word, applied;
	logic [2:0]                sp_cnt, spacing;
	logic [2:0]                sync_sr;
	agc_phase_e                phase;
	logic                      wr, setup, addr_ok, xfer_wr, hold_wr, sync_pulse, sync_load;
	logic                      bypass, dly_on, cnt_on, slot_start, early, intv_end, lg_sel;
	logic                      median, loop_en, accept, use_dly, out_ok, mag_done;
	logic [1:0]                mode;
	logic [31:0]               rdata;
	logic [MAG_W-1:0]          mag;
	logic signed [OUT_W-1:0]   meas_i, meas_q;
	logic signed [IN_W-1:0]    src_i, src_q;
	logic signed [ERR_W-1:0]   err;
	logic [LG_W-1:0]           lg_val;
	logic [15:0]               lg_pair;
	logic signed [SUM_W-1:0]   step, sum;

	// Shift by two to the exponent and multiply by one plus the mantissa.
	function automatic logic signed [OUT_W-1:0] fwd_scale(
		input logic signed [IN_W-1:0] x,
		input logic [GAIN_W-1:0]      g
	);
		logic signed [PROD_W-1:0] prod;
		logic signed [SH_W-1:0]   sh;
		prod = x * $signed({1'b0, 1'b1, g[MANT_W-1:0]});
		sh   = SH_W'(prod) <<< g[GAIN_W-1 -: EXP_W];
		sh   = sh >>> MANT_W;
		if (sh > SAT_MAX) begin
			fwd_scale = SAT_MAX;
		end else if (sh < SAT_MIN) begin
			fwd_scale = SAT_MIN;
		end else begin
			fwd_scale = sh[OUT_W-1:0];
		end
	endfunction : fwd_scale

	// Clamp a candidate accumulator value into the programmed gain range.
	function automatic logic [ACC_W-1:0] clamp(input logic signed [SUM_W-1:0] v);
		logic signed [SUM_W-1:0] lo, hi;
		lo = SUM_W'({lim_lo, {FRAC_W{1'b0}}});
		hi = SUM_W'({lim_hi, FRAC_ONES});
		if (v < lo) begin
			clamp = lo[ACC_W-1:0];
		end else if (v > hi) begin
			clamp = hi[ACC_W-1:0];
		end else begin
			clamp = v[ACC_W-1:0];
		end
	endfunction : clamp

	// APB decode; zero wait states, unmapped addresses answer with an error.
	assign wr      = PSEL && PENABLE && PWRITE;
	assign setup   = PSEL && !PENABLE;
	assign xfer_wr = wr && PADDR == A_XFER;
	assign hold_wr = wr && PADDR == A_HOLD;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;

	always_comb begin
		addr_ok = 1'b1;
		rdata   = 32'h0000_0000;
		case (PADDR)
			A_CTRL:    rdata = 32'(ctrl);
			A_THRESH:  rdata = 32'(thresh);
			A_LGAIN0:  rdata = 32'(lgain0);
			A_LGAIN1:  rdata = 32'(lgain1);
			A_LIMIT:   rdata = {lim_hi, lim_lo};
			A_HOLD:    rdata = 32'(hold);
			A_XFER:    rdata = 32'h0000_0000;
			A_SLOTLEN: rdata = 32'(slot_len);
			A_SDELAY:  rdata = 32'(sdelay);
			A_SINTV:   rdata = 32'(sintv);
			A_DLYLEN:  rdata = 32'(dly_len);
			A_GAIN:    rdata = {applied, gain_word};
			A_STATUS:  rdata = {26'h000_0000, sp_cnt, phase};
			default:   addr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			PRDATA <= 32'h0000_0000;
		end else if (setup) begin
			PRDATA <= rdata;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			ctrl     <= CTRL_RST;
			thresh   <= THRESH_RST;
			lgain0   <= 16'h0000;
			lgain1   <= 16'h0000;
			lim_hi   <= LIM_HI_RST;
			lim_lo   <= LIM_LO_RST;
			hold     <= 16'h0000;
			slot_len <= CNT_RST;
			sdelay   <= CNT_RST;
			sintv    <= CNT_RST;
			dly_len  <= 4'h0;
		end else if (wr) begin
			case (PADDR)
				A_CTRL:    ctrl     <= PWDATA[CTRL_W-1:0];
				A_THRESH:  thresh   <= PWDATA[MAG_W-1:0];
				A_LGAIN0:  lgain0   <= PWDATA[15:0];
				A_LGAIN1:  lgain1   <= PWDATA[15:0];
				A_LIMIT: begin
					lim_hi <= PWDATA[31:16];
					lim_lo <= PWDATA[15:0];
				end
				A_HOLD:    hold     <= PWDATA[GAIN_W-1:0];
				A_SLOTLEN: slot_len <= PWDATA[CNT_W-1:0];
				A_SDELAY:  sdelay   <= PWDATA[CNT_W-1:0];
				A_SINTV:   sintv    <= PWDATA[CNT_W-1:0];
				A_DLYLEN:  dly_len  <= PWDATA[DLY_AW-1:0];
				default: begin
				end
			endcase
		end
	end

	// Sync pin passes two flip-flops; the edge is taken after them.
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			sync_sr <= 3'h0;
		end else begin
			sync_sr <= {sync_sr[1:0], SLOT_SYNC_INPUT};
		end
	end
	assign sync_pulse = sync_sr[1] && !sync_sr[2];
	assign sync_load  = sync_pulse && ctrl[CB_SYNCLD];

	assign mode   = ctrl[CB_MODE +: 2];
	assign bypass = ctrl[CB_BYPASS];
	assign cnt_on = mode != MODE_CONT;
	assign dly_on = ctrl[CB_DLY] || mode == MODE_SAMPLED;

	// Slot counter with sync restart, then delay and interval phases.
	assign slot_start = cnt_on && ((sync_pulse && ctrl[CB_SYNCRS])
		|| slot_cnt == slot_len - 16'h0001);

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			slot_cnt <= CNT_RST;
		end else if (!cnt_on || slot_start) begin
			slot_cnt <= CNT_RST;
		end else begin
			slot_cnt <= slot_cnt + 16'h0001;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			phase <= PH_IDLE;
			pcnt  <= CNT_RST;
		end else if (!cnt_on) begin
			phase <= PH_IDLE;
		end else if (slot_start) begin
			phase <= PH_WAIT;
			pcnt  <= sdelay;
		end else begin
			case (phase)
				PH_WAIT: begin
					if (pcnt == CNT_RST) begin
						phase <= PH_INTV;
						pcnt  <= sintv;
					end else begin
						pcnt <= pcnt - 16'h0001;
					end
				end
				PH_INTV: begin
					if (pcnt == CNT_RST) begin
						phase <= PH_IDLE;
					end else begin
						pcnt <= pcnt - 16'h0001;
					end
				end
				PH_IDLE: phase <= PH_IDLE;
				default: phase <= PH_IDLE;
			endcase
		end
	end
	assign early    = phase == PH_INTV;
	assign intv_end = early && pcnt == CNT_RST;

	// Gain set and settling mode come from the host or from the counters.
	assign lg_sel  = cnt_on ? !early : ctrl[CB_HGSEL];
	assign median  = (cnt_on && ctrl[CB_CNTMODE]) ? early : ctrl[CB_HMED];
	assign loop_en = mode != MODE_SAMPLED || early;

	// Sample acceptance and spacing.
	always_comb begin
		if (bypass) begin
			spacing = SP_BYPASS;
		end else if (dly_on) begin
			spacing = SP_DLY;
		end else begin
			spacing = SP_NODLY;
		end
	end
	assign IN_READY = bypass || sp_cnt == 3'h0;
	assign accept   = IN_VALID && IN_READY;

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			sp_cnt <= 3'h0;
		end else if (accept) begin
			sp_cnt <= spacing - 3'h1;
		end else if (sp_cnt != 3'h0) begin
			sp_cnt <= sp_cnt - 3'h1;
		end
	end

	// Data delay: loop measures samples entering, output takes samples leaving.
	assign use_dly = dly_on && dly_len != 4'h0 && !bypass;
	assign rd_idx  = wp - dly_len;
	assign src_i   = use_dly ? dly_i[rd_idx] : IN_I;
	assign src_q   = use_dly ? dly_q[rd_idx] : IN_Q;
	assign out_ok  = !use_dly || fill >= {1'b0, dly_len};

	always_ff @(posedge CLK_SYS) begin
		if (accept && use_dly) begin
			dly_i[wp] <= IN_I;
			dly_q[wp] <= IN_Q;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			wp   <= 4'h0;
			fill <= 5'h00;
		end else if (!use_dly) begin
			fill <= 5'h00;
		end else if (accept) begin
			wp <= wp + 4'h1;
			if (fill != 5'h10) begin
				fill <= fill + 5'h01;
			end
		end
	end

	// Forward path uses a registered copy of the accumulator output; sampled mode updates it only at interval end.
	assign gain_word = acc[ACC_W-1 -: GAIN_W];
	assign GAIN_OUT  = applied;

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			applied <= 16'h0000;
		end else if (mode != MODE_SAMPLED || intv_end) begin
			applied <= gain_word;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			OUT_VALID <= 1'b0;
			OUT_I     <= '0;
			OUT_Q     <= '0;
		end else begin
			OUT_VALID <= accept && out_ok;
			if (accept && out_ok) begin
				OUT_I <= fwd_scale(src_i, bypass ? 16'h0000 : applied);
				OUT_Q <= fwd_scale(src_q, bypass ? 16'h0000 : applied);
			end
		end
	end

	// Magnitude of the scaled sample entering the delay; passes follow spacing.
	assign meas_i = fwd_scale(IN_I, gain_word);
	assign meas_q = fwd_scale(IN_Q, gain_word);

	agc_mag u_mag (
		.clk    (CLK_SYS),
		.nrst   (NRST),
		.start  (accept && !bypass),
		.in_i   (meas_i[OUT_W-1 -: MAG_IN_W]),
		.in_q   (meas_q[OUT_W-1 -: MAG_IN_W]),
		.passes (spacing),
		.done   (mag_done),
		.mag    (mag)
	);

	// Error, loop gain and integrator.
	assign err     = $signed({1'b0, thresh}) - $signed({1'b0, mag});
	assign lg_pair = lg_sel ? lgain1 : lgain0;
	assign lg_val  = (err < 0) ? lg_pair[LG_ATTACK +: LG_W] : lg_pair[LG_DECAY +: LG_W];

	always_comb begin
		if (median) begin
			step = SUM_W'($signed({1'b0, lg_val, {FRAC_W{1'b0}}}));
			if (err < 0) begin
				step = -step;
			end
		end else begin
			step = SUM_W'((err * $signed({1'b0, lg_val})) >>> MEAN_SHIFT);
		end
		sum = $signed(SUM_W'(acc)) + step;
	end

	always_comb begin
		if (xfer_wr || sync_load) begin
			next_acc = clamp(SUM_W'({hold, {FRAC_W{1'b0}}}));
		end else if (mag_done && loop_en) begin
			next_acc = clamp(sum);
		end else begin
			next_acc = acc;
		end
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			acc <= '0;
		end else begin
			acc <= next_acc;
		end
	end

	chk_gap_nodelay: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		accept && !bypass && !dly_on |=> !IN_READY || bypass)
		else $error("sample accepted one clock after another without delay");

	chk_gap_delay: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		accept && !bypass && ctrl[CB_DLY] && !wr |=> !IN_READY[*3])
		else $error("sample spacing below four clocks with delay on");

	chk_gap_sampled: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		accept && !bypass && mode == MODE_SAMPLED && !wr |=> !IN_READY[*3])
		else $error("sample spacing below four clocks in sampled mode");

	chk_bypass_rate: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		bypass |-> IN_READY)
		else $error("bypass stage not ready every clock");

	chk_hold_only: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		hold_wr && !mag_done && !sync_load |=> acc == $past(acc))
		else $error("holding register write changed the accumulator");

	chk_xfer_clamp: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		xfer_wr && lim_lo <= lim_hi |=> gain_word >= $past(lim_lo) && gain_word <= $past(lim_hi))
		else $error("transferred gain outside limits");

	chk_median_down: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		mag_done && loop_en && median && err < 0 && !xfer_wr && !sync_load
		&& gain_word >= lim_lo |=> gain_word <= $past(gain_word))
		else $error("median step raised gain on a negative error");

	chk_zero_gain: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		mag_done && !median && lg_val == 8'h00 && !xfer_wr && !sync_load
		&& gain_word >= lim_lo && gain_word <= lim_hi |=> $stable(acc))
		else $error("zero loop gain moved the accumulator");

	chk_sampled_hold: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		mode == MODE_SAMPLED && !intv_end |=> $stable(applied))
		else $error("applied gain moved outside the update point");

endmodule : agc_loop

// [sim/agc_src.sv]
`timescale 1ns/1ps
module agc_src
	import agc_pkg::*;
(
	// Bench side.
	input  wire logic                    clk,
	input  wire logic                    nrst,
	input  wire logic                    start,
	input  wire logic [3:0]              num,
	input  wire logic signed [IN_W-1:0]  base,
	output logic                         busy,
	output logic [7:0]                   gap,
	output logic signed [OUT_W-1:0]      got_i,
	// Gain stage side.
	input  wire logic                    in_ready,
	output logic                         in_valid,
	output logic signed [IN_W-1:0]       in_i,
	output logic signed [IN_W-1:0]       in_q,
	input  wire logic                    out_valid,
	input  wire logic signed [OUT_W-1:0] out_i
);
	logic [3:0]             left;
	logic [7:0]             cnt;
	logic signed [IN_W-1:0] next_i;

	assign busy   = left != 4'h0;
	assign next_i = in_i + 20'h0_0001;

	// A sample stands until an edge sees ready; idle lines show the inverse.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			left     <= 4'h0;
			in_valid <= 1'b0;
			in_i     <= '0;
			in_q     <= '0;
		end else if (start) begin
			left     <= num;
			in_valid <= 1'b1;
			in_i     <= base;
			in_q     <= -base;
		end else if (in_valid && in_ready) begin
			left     <= left - 4'h1;
			in_valid <= left != 4'h1;
			in_i     <= (left != 4'h1) ? next_i : ~in_i;
			in_q     <= (left != 4'h1) ? -next_i : ~in_q;
		end
	end

	// Counts clocks between accepts and keeps the last scaled sample.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt   <= 8'h00;
			gap   <= 8'h00;
			got_i <= '0;
		end else begin
			cnt <= (in_valid && in_ready) ? 8'h01 : cnt + 8'h01;
			if (in_valid && in_ready) begin
				gap <= cnt;
			end
			if (out_valid) begin
				got_i <= out_i;
			end
		end
	end
endmodule : agc_src

// [sim/agc_loop_tb.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin num_errors++; \
	$display("ERROR %s exp %0h got %0h", nm, ex, gt); end end
module agc_loop_tb
	import agc_pkg::*;
;
	logic                    clk_sys = 1'b0;
	logic                    nrst = 1'b0;
	logic                    psel = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite = 1'b0;
	logic [ADDR_W-1:0]       paddr = 8'h00;
	logic [31:0]             pwdata = 32'h0000_0000;
	logic                    start = 1'b0;
	logic                    sync_in = 1'b0;
	logic [3:0]              num = 4'h1;
	logic signed [IN_W-1:0]  base = 20'h0_0000;
	logic signed [IN_W-1:0]  in_i, in_q;
	logic signed [OUT_W-1:0] out_i, out_q, got_i;
	logic [31:0]             prdata, rd;
	logic                    pready, pslverr, err, in_valid, in_ready, out_valid, busy;
	logic [7:0]              gap;
	logic [GAIN_W-1:0]       gain_out;
	int                      num_errors = 0;
	int                      comparisons = 0;

	always #25 clk_sys = ~clk_sys;

	agc_loop agc_loop_inst (.CLK_SYS(clk_sys), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SLOT_SYNC_INPUT(sync_in), .IN_VALID(in_valid), .IN_READY(in_ready),
		.IN_I(in_i), .IN_Q(in_q), .OUT_VALID(out_valid), .OUT_I(out_i), .OUT_Q(out_q),
		.GAIN_OUT(gain_out));
	agc_src agc_src_inst (.clk(clk_sys), .nrst(nrst), .start(start), .num(num), .base(base),
		.busy(busy), .gap(gap), .got_i(got_i), .in_ready(in_ready), .in_valid(in_valid),
		.in_i(in_i), .in_q(in_q), .out_valid(out_valid), .out_i(out_i));

	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (n == 50) begin
			num_errors++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, ex, rd)
	endtask : rdc

	task automatic load(input logic [15:0] w);
		wr(A_HOLD, {16'h0000, w});
		wr(A_XFER, 32'h0000_0000);
	endtask : load

	task automatic send(input logic [3:0] n, input logic signed [IN_W-1:0] b);
		int k;
		num   <= n;
		base  <= b;
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		for (k = 0; k < 100; k++) begin
			@(negedge clk_sys);
			if (busy === 1'b0) break;
		end
		if (k == 100) begin
			num_errors++;
			tally_and_finish();
		end
		repeat (8) @(posedge clk_sys);
	endtask : send

	task automatic t_regs;
		rdc("limit", A_LIMIT, 32'hFFFF_0000);
		rdc("hole", 8'h3C, 32'h0000_0000);
		`CHK("slverr", 1'b1, err)
	endtask : t_regs

	task automatic t_xfer;
		wr(A_HOLD, 32'h0000_1234);
		rdc("noload", A_GAIN, 32'h0000_0000);
		wr(A_XFER, 32'h0000_0000);
		rdc("xfer", A_GAIN, 32'h1234_1234);
		`CHK("gainpin", 16'h1234, gain_out)
		wr(A_LIMIT, 32'h2000_1000);
		load(16'h3000);
		rdc("clamp", A_GAIN, 32'h2000_2000);
		wr(A_LIMIT, 32'hFFFF_0000);
	endtask : t_xfer

	task automatic t_fwd;
		load(16'h1800);
		send(4'h1, 20'h0_03E8);
		`CHK("scale", 24'h00_0BB8, got_i)
		`CHK("scaleq", 24'hFF_F448, out_q)
		load(16'hF000);
		send(4'h1, 20'h1_86A0);
		`CHK("sat", SAT_MAX, got_i)
		`CHK("satq", SAT_MIN, out_q)
		rdc("fixed", A_GAIN, 32'hF000_F000);
	endtask : t_fwd

	task automatic t_space;
		logic [8:0] cw [4] = '{9'h001, 9'h000, 9'h002, 9'h008};
		logic [7:0] sp [4] = '{8'h01, 8'h02, 8'h04, 8'h04};
		load(16'h0000);
		wr(A_DLYLEN, 32'h0000_0002);
		for (int k = 0; k < 4; k++) begin
			wr(A_CTRL, {23'h00_0000, cw[k]});
			send(4'h3, 20'h0_0100);
			`CHK("spacing", sp[k], gap)
			if (k == 2) `CHK("delayed", 24'h00_0100, got_i)
		end
		wr(A_CTRL, 32'h0000_0000);
	endtask : t_space

	task automatic t_loop;
		load(16'h1000);
		wr(A_LGAIN0, 32'h0000_0305);
		wr(A_LGAIN1, 32'h0000_0702);
		wr(A_THRESH, 32'h0000_1000);
		wr(A_CTRL, 32'h0000_0080);
		send(4'h1, 20'h0_0000);
		rdc("medup", A_GAIN, 32'h1003_1003);
		wr(A_CTRL, 32'h0000_00C0);
		send(4'h1, 20'h0_0000);
		rdc("selup", A_GAIN, 32'h100A_100A);
		wr(A_THRESH, 32'h0000_0000);
		send(4'h1, 20'h1_86A0);
		rdc("meddn", A_GAIN, 32'h1008_1008);
		wr(A_LGAIN1, 32'h0000_1000);
		wr(A_THRESH, 32'h0000_1000);
		wr(A_CTRL, 32'h0000_0040);
		send(4'h1, 20'h0_0000);
		rdc("mean", A_GAIN, 32'h1018_1018);
	endtask : t_loop

	task automatic t_sync;
		wr(A_CTRL, 32'h0000_0010);
		wr(A_HOLD, 32'h0000_0ABC);
		sync_in <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sync_in <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rdc("syncld", A_GAIN, 32'h0ABC_0ABC);
		wr(A_CTRL, 32'h0000_0000);
	endtask : t_sync

	task automatic t_timed;
		wr(A_SINTV, 32'h0000_0100);
		wr(A_SLOTLEN, 32'h0000_0400);
		load(16'h1000);
		wr(A_CTRL, 32'h0000_0124);
		sync_in <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sync_in <= 1'b0;
		send(4'h1, 20'h0_0000);
		rdc("tearly", A_GAIN, 32'h1003_1003);
		repeat (300) @(posedge clk_sys);
		send(4'h1, 20'h0_0000);
		rdc("tlate", A_GAIN, 32'h1013_1013);
		wr(A_CTRL, 32'h0000_0000);
	endtask : t_timed

	initial begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_xfer();
		t_sync();
		t_fwd();
		t_space();
		t_loop();
		t_timed();
		tally_and_finish();
	end
endmodule : agc_loop_tb
